//--- ecac_regs.svh
// Register offsets, field positions, reset values and timing counts of the EEPROM access controller.
`ifndef ECAC_REGS_SVH
`define ECAC_REGS_SVH

// ----------------------------------------------------------------------------
// Widths and array size
// ----------------------------------------------------------------------------
`define ECAC_NV_BYTES        512
`define ECAC_AW              9
`define ECAC_PAW             12
`define ECAC_CW              15

// ----------------------------------------------------------------------------
// Byte offsets on the APB
// ----------------------------------------------------------------------------
`define ECAC_OFS_ADDR        12'h000
`define ECAC_OFS_DATA        12'h004
`define ECAC_OFS_CTRL        12'h008
`define ECAC_OFS_STAT        12'h00C

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define ECAC_CTRL_RD         0
`define ECAC_CTRL_WR         1
`define ECAC_CTRL_ARM        2
`define ECAC_CTRL_RIE        3
`define ECAC_STAT_SPM        0
`define ECAC_STAT_BUSY       1
`define ECAC_STAT_KEEP       2

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define ECAC_ADDR_RST        9'h000
`define ECAC_DATA_RST        8'h00
`define ECAC_ARM_CYCLES      3'h4
`define ECAC_RD_STALL        3'h4
`define ECAC_WR_STALL        3'h2
`define ECAC_WR_OSC_CYCLES   15'd27072

`endif

//--- ecac_pkg.sv
// Types shared by the EEPROM access controller.
`include "ecac_regs.svh"

package ecac_pkg;

	typedef struct packed {
		logic                  psel;
		logic                  penable;
		logic                  pwrite;
		logic [`ECAC_PAW-1:0]  paddr;
		logic [31:0]           pwdata;
	} ecac_apb_req_t;

	typedef struct packed {
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
	} ecac_apb_rsp_t;

	typedef struct packed {
		logic [`ECAC_AW-1:0]   addr;
		logic [7:0]            data;
		logic                  rie;
		logic                  arm;
		logic                  wstrobe;
		logic [2:0]            arm_cnt;
		logic [2:0]            stall_cnt;
		logic [2:0]            osc_sync;
		logic [7:0]            rdata;
	} ecac_ctl_t;

	typedef struct packed {
		logic [`ECAC_NV_BYTES-1:0][7:0] mem;
		logic [`ECAC_CW-1:0]            cnt;
		logic                           busy;
		logic [`ECAC_AW-1:0]            addr;
		logic [7:0]                     data;
	} ecac_eng_t;

endpackage

//--- ecac_nv_array.sv
// Byte array and self-timed write engine of the EEPROM access controller.
`timescale 1ns/1ps
`include "ecac_regs.svh"

module ecac_nv_array
	import ecac_pkg::*;
#(
	parameter logic [`ECAC_CW-1:0] WRITE_OSC_CYCLES = `ECAC_WR_OSC_CYCLES
) (
	// Clock, reset and enable.
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                ce_i,
	// Oscillator tick and write request.
	input  wire logic                tick_i,
	input  wire logic                start_i,
	input  wire logic [`ECAC_AW-1:0] waddr_i,
	input  wire logic [7:0]          wdata_i,
	// Read port and status.
	input  wire logic [`ECAC_AW-1:0] raddr_i,
	output logic [7:0]               rdata_o,
	output logic                     busy_o
);

	ecac_eng_t q;
	ecac_eng_t d;

	// ------------------------------------------------------------------------
	// Write engine
	// ------------------------------------------------------------------------
	// The engine has its own reset so that a system reset does not cut a write short.
	always_comb begin
		d = q;
		if (start_i && !q.busy) begin
			d.busy = 1'b1;
			d.cnt  = WRITE_OSC_CYCLES;
			d.addr = waddr_i;
			d.data = wdata_i;
		end else if (q.busy && tick_i) begin
			d.cnt = q.cnt - `ECAC_CW'(1);
			if (q.cnt == `ECAC_CW'(1)) begin
				d.mem[q.addr] = q.data;
				d.busy        = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign rdata_o = q.mem[raddr_i];
	assign busy_o  = q.busy;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i || !ce_i);

	eng_load_a: assert property (start_i && !q.busy |=> q.busy && q.cnt == WRITE_OSC_CYCLES)
		else $error("write engine did not load its full duration");
	eng_done_a: assert property (q.busy && tick_i && q.cnt == `ECAC_CW'(1)
		|=> !q.busy && q.mem[q.addr] == $past(q.data))
		else $error("write engine did not finish on its last tick");
	eng_done_c: cover property (q.busy ##1 !q.busy);

endmodule

//--- ecac_top.sv
// CPU access controller for the on-chip data EEPROM, with APB register slave.
`timescale 1ns/1ps
`include "ecac_regs.svh"

module ecac_top
	import ecac_pkg::*;
#(
	parameter logic [`ECAC_CW-1:0] WRITE_OSC_CYCLES = `ECAC_WR_OSC_CYCLES
) (
	// Clock, resets and clock enable.
	input  wire logic          core_clk_i,
	input  wire logic          nrst_i,
	input  wire logic          por_n_i,
	input  wire logic          ce_i,
	// APB slave.
	input  wire ecac_apb_req_t apb_req_i,
	output ecac_apb_rsp_t      apb_rsp_o,
	// Calibrated RC oscillator, asynchronous to the core clock.
	input  wire logic          osc_clk_i,
	// Flash self-programming handshake.
	input  wire logic          self_program_busy_i,
	output logic               nv_busy_o,
	// Core, sleep and interrupt.
	input  wire logic          power_down_i,
	output logic               cpu_stall_o,
	output logic               ready_irq_o,
	output logic               osc_keep_o,
	output logic               full_power_down_o
);

	// ------------------------------------------------------------------------
	// Reset synchronisers
	// ------------------------------------------------------------------------
	logic [1:0] rst_pipe_q;
	logic [1:0] por_pipe_q;
	logic       rst_n;
	logic       por_n;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end

	always_ff @(posedge core_clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			por_pipe_q <= 2'h0;
		end else begin
			por_pipe_q <= {por_pipe_q[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe_q[1];
	assign por_n = por_pipe_q[1];

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic reg_hit(
		input logic [`ECAC_PAW-1:0] a,
		input logic [`ECAC_PAW-1:0] ofs
	);
		return a == ofs;
	endfunction

	function automatic logic [2:0] count_down(input logic [2:0] c);
		return (c == 3'h0) ? 3'h0 : c - 3'h1;
	endfunction

	// ------------------------------------------------------------------------
	// State and decode
	// ------------------------------------------------------------------------
	ecac_ctl_t           q;
	ecac_ctl_t           d;
	logic                eng_busy;
	logic [7:0]          eng_rdata;
	logic                osc_tick;
	logic                busy;
	logic                access;
	logic                wr_acc;
	logic                mapped;
	logic                ctrl_wr;
	logic                arm_set;
	logic                rd_go;
	logic                wr_go;
	logic [7:0]          rd_mux;
	logic [`ECAC_PAW-1:0] pa;

	assign pa = apb_req_i.paddr;

	// The first sync stage feeds only the second; the edge uses stages two and three.
	assign osc_tick = q.osc_sync[1] && !q.osc_sync[2];

	assign busy    = q.wstrobe || eng_busy;
	assign mapped  = reg_hit(pa, `ECAC_OFS_ADDR) || reg_hit(pa, `ECAC_OFS_DATA)
		|| reg_hit(pa, `ECAC_OFS_CTRL) || reg_hit(pa, `ECAC_OFS_STAT);
	assign access  = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
	assign wr_acc  = access && apb_req_i.pwrite && mapped;
	assign ctrl_wr = wr_acc && reg_hit(pa, `ECAC_OFS_CTRL);

	// Arming needs the strobe written as zero in the same write.
	assign arm_set = ctrl_wr && apb_req_i.pwdata[`ECAC_CTRL_ARM]
		&& !apb_req_i.pwdata[`ECAC_CTRL_WR];

	// A write starts only inside the arm window and with both parties idle.
	assign wr_go = ctrl_wr && apb_req_i.pwdata[`ECAC_CTRL_WR] && q.arm
		&& !busy && !self_program_busy_i;

	// A read during a write is dropped silently.
	assign rd_go = ctrl_wr && apb_req_i.pwdata[`ECAC_CTRL_RD] && !busy;

	// ------------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		if (reg_hit(pa, `ECAC_OFS_ADDR)) begin
			rd_mux = q.addr[7:0];
		end else if (reg_hit(pa, `ECAC_OFS_DATA)) begin
			rd_mux = q.data;
		end else if (reg_hit(pa, `ECAC_OFS_CTRL)) begin
			rd_mux[`ECAC_CTRL_RIE] = q.rie;
			rd_mux[`ECAC_CTRL_ARM] = q.arm;
			rd_mux[`ECAC_CTRL_WR]  = q.wstrobe;
		end else if (reg_hit(pa, `ECAC_OFS_STAT)) begin
			rd_mux[`ECAC_STAT_SPM]  = self_program_busy_i;
			rd_mux[`ECAC_STAT_BUSY] = eng_busy;
			rd_mux[`ECAC_STAT_KEEP] = eng_busy && power_down_i;
		end
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		d = q;
		d.osc_sync  = {q.osc_sync[1:0], osc_clk_i};
		d.arm_cnt   = count_down(q.arm_cnt);
		d.stall_cnt = count_down(q.stall_cnt);
		if (q.arm_cnt == 3'h1) begin
			d.arm = 1'b0;
		end
		if (q.wstrobe && !eng_busy) begin
			d.wstrobe = 1'b0;
		end
		// Read data is sampled in the setup phase and sampled again each cycle while the core stalls.
		if (apb_req_i.psel && (!apb_req_i.penable || !apb_rsp_o.pready)) begin
			d.rdata = rd_mux;
		end
		if (wr_acc && reg_hit(pa, `ECAC_OFS_ADDR) && !busy) begin
			d.addr = apb_req_i.pwdata[`ECAC_AW-1:0];
		end
		if (wr_acc && reg_hit(pa, `ECAC_OFS_DATA)) begin
			d.data = apb_req_i.pwdata[7:0];
		end
		if (ctrl_wr) begin
			d.rie = apb_req_i.pwdata[`ECAC_CTRL_RIE];
		end
		if (arm_set) begin
			d.arm     = 1'b1;
			d.arm_cnt = `ECAC_ARM_CYCLES;
		end
		if (wr_go) begin
			d.wstrobe   = 1'b1;
			d.stall_cnt = `ECAC_WR_STALL;
		end
		if (rd_go) begin
			d.data      = eng_rdata;
			d.stall_cnt = `ECAC_RD_STALL;
		end
	end

	// Control bits return to zero on system reset; the engine keeps its own reset.
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q      <= '0;
			q.addr <= `ECAC_ADDR_RST;
			q.data <= `ECAC_DATA_RST;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------------
	// Array and write engine
	// ------------------------------------------------------------------------
	ecac_nv_array #(
		.WRITE_OSC_CYCLES (WRITE_OSC_CYCLES)
	) u_array (
		.core_clk_i (core_clk_i),
		.rst_n_i    (por_n),
		.ce_i       (ce_i),
		.tick_i     (osc_tick),
		.start_i    (wr_go),
		.waddr_i    (q.addr),
		.wdata_i    (q.data),
		.raddr_i    (q.addr),
		.rdata_o    (eng_rdata),
		.busy_o     (eng_busy)
	);

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	// The core is held off the bus while it is stalled.
	assign apb_rsp_o.pready  = (q.stall_cnt == 3'h0);
	assign apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && !mapped;
	assign apb_rsp_o.prdata  = {24'h000000, q.rdata};

	assign cpu_stall_o       = (q.stall_cnt != 3'h0);
	assign ready_irq_o       = q.rie && !q.wstrobe;
	assign nv_busy_o         = busy;
	// The oscillator keeps running until a write in progress has finished.
	assign osc_keep_o        = eng_busy;
	assign full_power_down_o = power_down_i && !eng_busy;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n || !ce_i);

	arm_hold_a: assert property (arm_set |=> q.arm [*4])
		else $error("master arm bit dropped inside its window");

	arm_expire_a: assert property (arm_set ##1 !arm_set [*4] |=> !q.arm)
		else $error("master arm bit not cleared after four cycles");

	rd_stall_a: assert property (rd_go |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
		else $error("read stall is not four cycles");

	wr_stall_a: assert property (wr_go |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
		else $error("write stall is not two cycles");

	no_arm_a: assert property (ctrl_wr && apb_req_i.pwdata[`ECAC_CTRL_WR] && !q.arm
		|=> !eng_busy || $past(eng_busy))
		else $error("write started without the master arm bit");

	spm_block_a: assert property (self_program_busy_i && !busy |=> !q.wstrobe)
		else $error("write started during flash self-programming");

	addr_lock_a: assert property (busy |=> $stable(q.addr))
		else $error("address changed during a write");

	strobe_clear_a: assert property ($fell(eng_busy) |=> !q.wstrobe)
		else $error("write strobe not cleared after the write");

	rd_data_a: assert property (rd_go |=> q.data == $past(eng_rdata))
		else $error("read did not load the addressed byte");

	irq_ready_a: assert property ($fell(eng_busy) && q.rie |=> ready_irq_o)
		else $error("ready request missing after write end");

	wr_flow_c: cover property (arm_set ##[1:4] wr_go);
	rd_flow_c: cover property (rd_go ##5 access);
	arm_lapse_c: cover property (arm_set ##1 !wr_go [*5]);
	sleep_hold_c: cover property (power_down_i && eng_busy);

endmodule

//--- ecac_core_model.sv
// Processor core model that issues APB register transfers to the EEPROM controller.
`timescale 1ns/1ps

module ecac_core_model
	import ecac_pkg::*;
(
	// Clock.
	input  wire logic          core_clk_i,
	// APB master side.
	input  wire ecac_apb_rsp_t apb_rsp_i,
	output ecac_apb_req_t      apb_req_o
);

	initial apb_req_o = '0;

	// One transfer: a setup cycle, then access until pready is sampled high.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge core_clk_i);
		apb_req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge core_clk_i);
		apb_req_o.penable <= 1'b1;
		@(posedge core_clk_i);
		while (apb_rsp_i.pready !== 1'b1) @(posedge core_clk_i);
		rd = apb_rsp_i.prdata;
		err = apb_rsp_i.pslverr;
		apb_req_o <= '0;
	endtask

endmodule

//--- eeprom_cpu_access_controller_bench.sv
// Self-checking bench of the EEPROM access controller with random and corner-case traffic.
`timescale 1ns/1ps
`include "ecac_regs.svh"

module eeprom_cpu_access_controller_bench
	import ecac_pkg::*;
;

	localparam int          OSC_PER = 83;
	localparam logic [14:0] N_OSC   = 15'd8;

	logic          core_clk_i          = 1'b0;
	logic          osc_clk_i           = 1'b0;
	logic          nrst_i              = 1'b0;
	logic          por_n_i             = 1'b0;
	logic          self_program_busy_i = 1'b0;
	logic          power_down_i        = 1'b0;
	ecac_apb_req_t apb_req;
	ecac_apb_rsp_t apb_rsp;
	logic          nv_busy_o;
	logic          cpu_stall_o;
	logic          ready_irq_o;
	logic          osc_keep_o;
	logic          full_power_down_o;
	logic [7:0]    exp_mem [0:511];
	logic [31:0]   rv;
	logic          err;
	int            errors          = 0;
	int            samples_checked = 0;
	int            cycles          = 0;
	int            stall_run       = 0;
	int            stall_len       = 0;
	int            stall_num       = 0;
	integer        seed            = 32'hD9229ABE;

	always #10 core_clk_i = ~core_clk_i;
	always #41.5 osc_clk_i = ~osc_clk_i;

	ecac_top #(.WRITE_OSC_CYCLES(N_OSC)) i_ecac_top (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .por_n_i(por_n_i), .ce_i(1'b1),
		.apb_req_i(apb_req), .apb_rsp_o(apb_rsp), .osc_clk_i(osc_clk_i),
		.self_program_busy_i(self_program_busy_i), .nv_busy_o(nv_busy_o),
		.power_down_i(power_down_i), .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o),
		.osc_keep_o(osc_keep_o), .full_power_down_o(full_power_down_o)
	);

	ecac_core_model i_ecac_core_model (
		.core_clk_i(core_clk_i), .apb_rsp_i(apb_rsp), .apb_req_o(apb_req)
	);

	// ------------------------------------------------------------------------
	// Checking and transfer tasks
	// ------------------------------------------------------------------------
	task automatic finish_test();
		$display("Comparisons: %0d, mismatches: %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_ecac_core_model.xfer(1'b1, a, d, rv, err);
	endtask

	task automatic rd(input logic [11:0] a);
		i_ecac_core_model.xfer(1'b0, a, 32'h0, rv, err);
	endtask

	// Polls bit 1 of control (write strobe) or status (engine busy) until clear.
	task automatic wait_done(input logic [11:0] a);
		int n;
		n = 0;
		do begin
			rd(a);
			n++;
		end while (rv[1] !== 1'b0 && n < 400);
	endtask

	task automatic nv_write(input logic [8:0] a, input logic [7:0] d, input int gap,
			input logic go, input logic rie);
		time t0;
		int  s0;
		wr(`ECAC_OFS_DATA, {24'h0, d});
		wr(`ECAC_OFS_ADDR, {23'h0, a});
		wr(`ECAC_OFS_CTRL, {28'h0, rie, 3'b100});
		repeat (gap) @(posedge core_clk_i);
		wr(`ECAC_OFS_CTRL, {28'h0, rie, 3'b010});
		t0 = $time;
		s0 = stall_num;
		repeat (4) @(posedge core_clk_i);
		chk(nv_busy_o, go);
		chk(osc_keep_o, go);
		chk(full_power_down_o, power_down_i & !go);
		chk(ready_irq_o, rie & !go);
		if (go) begin
			chk(stall_len, 2);
			exp_mem[a] = d;
			wr(`ECAC_OFS_ADDR, {23'h0, ~a});
			rd(`ECAC_OFS_ADDR);
			chk(rv, {24'h0, a[7:0]});
			s0 = stall_num;
			wr(`ECAC_OFS_CTRL, {28'h0, rie, 3'b001});
			wait_done(`ECAC_OFS_CTRL);
			chk(($time - t0) >= (N_OSC - 1) * OSC_PER, 1);
			chk(($time - t0) <= N_OSC * OSC_PER + 700, 1);
			chk(stall_num, s0);
			chk(full_power_down_o, power_down_i);
			chk(ready_irq_o, rie);
		end else begin
			chk(stall_num, s0);
		end
	endtask

	task automatic nv_read(input logic [8:0] a);
		wr(`ECAC_OFS_ADDR, {23'h0, a});
		wr(`ECAC_OFS_CTRL, 32'h1);
		rd(`ECAC_OFS_DATA);
		chk(rv, {24'h0, exp_mem[a]});
		repeat (2) @(posedge core_clk_i);
		chk(stall_len, 4);
	endtask

	// ------------------------------------------------------------------------
	// Stall length monitor and run limit
	// ------------------------------------------------------------------------
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cpu_stall_o === 1'b1) begin
			stall_run <= stall_run + 1;
		end else if (stall_run != 0) begin
			stall_len <= stall_run;
			stall_num <= stall_num + 1;
			stall_run <= 0;
		end
		if (cycles == 40000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		logic [8:0] a;
		for (int i = 0; i < 512; i++) exp_mem[i] = 8'h00;
		repeat (16) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		por_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rd(`ECAC_OFS_CTRL);
		chk(rv, 32'h0);
		rd(`ECAC_OFS_ADDR);
		chk(rv, 32'h0);
		rd(12'h010);
		chk({rv[30:0], err}, 32'h1);
		wr(`ECAC_OFS_CTRL, 32'h4);
		rd(`ECAC_OFS_CTRL);
		chk(rv, 32'h4);
		repeat (2) @(posedge core_clk_i);
		rd(`ECAC_OFS_CTRL);
		chk(rv, 32'h0);
		// Late strobe, flash programming busy, then the last legal strobe slot.
		nv_write(9'h0AA, 8'h55, 2, 1'b0, 1'b0);
		self_program_busy_i <= 1'b1;
		nv_write(9'h0AB, 8'h66, 0, 1'b0, 1'b1);
		rd(`ECAC_OFS_STAT);
		chk(rv, 32'h1);
		self_program_busy_i <= 1'b0;
		nv_read(9'h0AA);
		nv_read(9'h0AB);
		nv_write(9'h100, 8'hC3, 1, 1'b1, 1'b0);
		nv_read(9'h100);
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
			power_down_i <= i[0];
			nv_write(a, 8'($random(seed)), i % 2, 1'b1, i[1]);
			nv_read(a);
		end
		power_down_i <= 1'b0;
		// System reset in mid-write lets the write finish.
		wr(`ECAC_OFS_DATA, 32'h5A);
		wr(`ECAC_OFS_CTRL, 32'h4);
		wr(`ECAC_OFS_CTRL, 32'h2);
		exp_mem[a] = 8'h5A;
		nrst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		chk(nv_busy_o, 1);
		wait_done(`ECAC_OFS_STAT);
		nv_read(a);
		finish_test();
	end

endmodule
